// ---- verilog/swd_decoder.sv ----
// Selective-wake frame decoder with AHB-Lite register slave
// How it works
// - Wake restarts in sleep, interrupts otherwise
// - Wake sets flag; cause bits tell why
// - Bit quanta count plus clock select timing
// - Select bit picks decoder receiver path
// - Measure enable, CAN off, pulse counted
// - Trim writes only with enable and 11
// - Tolerance enable bit turns mode on
// - Fast frames: no checks, no selective wake
// - Decoder ready again after frame end
// - EDL one halts, zero continues decoding
// - Filter sets minimum accepted dominant time
// - Tolerance off: up on bad, down good
// - Tolerance on, hold off: down any good
// - Tolerance and hold: counter kept zero
// - Silence expiry clears counter hold bit
// - Recovery tracks bit stream, adjusts timing
// - Limit exceeded: reload programmed bit time
// - Silence timeout between 0.6 and 1.2 s
// - Counter overflow wakes, reads 100000
// - Tolerance on: filter drops short fast dominant pulses
`timescale 1ns/100ps
module swd_decoder import swd_pkg::*; #(
    parameter int SILENCE = SILENCE_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Bus side pins, recessive high
    input wire logic rx_main,
    input wire logic rx_wake,
    input wire logic can_transmit_input,
    // Chip state and wake signalling
    input wire logic chip_sleep,
    output logic wake_irq,
    output logic restart_req,
    // Oscillator adjust values
    output logic [7:0] osc_trim,
    output logic [7:0] osc_option
);
    // Silence counter is 24 bits wide
    if (SILENCE < 1 || SILENCE > 24'hffffff) begin : g_chk
        $error("SILENCE out of range");
    end
    localparam logic [23:0] SIL_LAST = 24'(SILENCE - 1);

    swd_st_t s_q, s_d; // State record
    logic acc; // Address phase taken
    logic wr; // Write data phase
    logic [2:0] c; // Selected receiver chain
    logic rx_f; // Filtered receive level
    logic tq_en; // One quantum elapsed
    logic smp; // Sample point pulse
    logic fall; // Recessive to dominant edge
    logic [5:0] nb; // Recovered bit length
    logic lim_hit; // Recovery out of limits
    logic stuffed; // Current bit is a stuff bit
    logic serr; // Stuff violation
    logic eof; // Seventh recessive bit
    logic fd_det; // Fast frame detected
    logic good_cls, good_fd; // Frames ended cleanly
    logic inc, dec; // Counter steps
    logic wuf_ev, pat_ev, ovf_ev, wk_ev; // Wake causes
    logic sil_exp; // Silence expiry pulse
    logic meas; // Oscillator measuring

    // Next state of everything
    always_comb begin
        s_d = s_q;
        // Bus front end; reads take one wait state so writes land first
        acc = hsel && hready && htrans[1] && hsize == 3'h2;
        wr = s_q.ap && s_q.aw;
        s_d.ap = acc;
        s_d.rdy = !(acc && !hwrite);
        if (acc) begin
            s_d.aa = haddr[31:8] == '0 ? haddr[7:0] : 8'hff;
            s_d.aw = hwrite;
        end
        if (s_q.ap && !s_q.aw) begin
            case (s_q.aa)
                A_CTRL: s_d.rdata = {21'h0, s_q.trim_en, s_q.osc_en, 1'b0, s_q.mode,
                    1'b0, s_q.rxsel, s_q.hold, s_q.tol};
                A_BITQ: s_d.rdata = {26'h0, s_q.bt};
                A_SAMP: s_d.rdata = {26'h0, s_q.sp};
                A_RCTL: s_d.rdata = {31'h0, s_q.recovery_enable};
                A_RCLK: s_d.rdata = {30'h0, s_q.csel};
                A_RHI: s_d.rdata = {26'h0, s_q.lhi};
                A_RLO: s_d.rdata = {26'h0, s_q.llo};
                A_FILT: s_d.rdata = {24'h0, s_q.filt};
                A_WID: s_d.rdata = {21'h0, s_q.wid};
                A_WMSK: s_d.rdata = {21'h0, s_q.wmsk};
                A_STAT: s_d.rdata = {18'h0, s_q.frame_error_count, 4'h0, s_q.cfg, s_q.wuf,
                    s_q.pat, s_q.wake};
                A_OSCH: s_d.rdata = {24'h0, s_q.osc[15:8]};
                A_OSCL: s_d.rdata = {24'h0, s_q.osc[7:0]};
                A_TRIM: s_d.rdata = {24'h0, s_q.trim};
                A_OPT: s_d.rdata = {24'h0, s_q.opt};
                default: s_d.rdata = '0; // Unmapped reads zero
            endcase
        end
        // Register writes; status bits clear on one
        if (wr) begin
            case (s_q.aa)
                A_CTRL: begin
                    s_d.tol = hwdata[0];
                    s_d.hold = hwdata[1];
                    s_d.rxsel = hwdata[2];
                    s_d.mode = hwdata[6:4];
                    s_d.osc_en = hwdata[8];
                    s_d.trim_en = hwdata[10:9];
                end
                A_BITQ: s_d.bt = hwdata[5:0];
                A_SAMP: s_d.sp = hwdata[5:0];
                A_RCTL: s_d.recovery_enable = hwdata[0];
                A_RCLK: s_d.csel = hwdata[1:0];
                A_RHI: s_d.lhi = hwdata[5:0];
                A_RLO: s_d.llo = hwdata[5:0];
                A_FILT: s_d.filt = hwdata[7:0];
                A_WID: s_d.wid = hwdata[10:0];
                A_WMSK: s_d.wmsk = hwdata[10:0];
                A_STAT: begin
                    s_d.wake = s_q.wake && !hwdata[0];
                    s_d.pat = s_q.pat && !hwdata[1];
                    s_d.wuf = s_q.wuf && !hwdata[2];
                    s_d.cfg = s_q.cfg && !hwdata[3];
                    if (hwdata[4]) s_d.frame_error_count = '0;
                end
                // Trim is locked unless the measure enable and both trim enable bits are set
                A_TRIM: if (s_q.osc_en && s_q.trim_en == 2'b11) s_d.trim = hwdata[7:0];
                A_OPT: if (s_q.osc_en && s_q.trim_en == 2'b11) s_d.opt = hwdata[7:0];
                default: ;
            endcase
        end

        // Pin synchronisers; a level counts once stages two and three agree
        s_d.ra = {s_q.ra[1:0], rx_main};
        s_d.rb = {s_q.rb[1:0], rx_wake};
        s_d.tx = {s_q.tx[1:0], can_transmit_input};
        c = s_q.rxsel ? s_q.rb : s_q.ra;
        if (c[2] == c[1]) s_d.rxs = c[2];
        if (s_q.tx[2] == s_q.tx[1]) s_d.txs = s_q.tx[2];

        // Short dominant pulses inside a skipped fast frame are ignored when tolerance is on
        s_d.dom = s_q.rxs ? 8'h00 : (s_q.dom == 8'hff ? s_q.dom : s_q.dom + 8'h01);
        rx_f = s_q.rxs || (s_q.fs == FS_SKIP && s_q.tol && s_q.dom < s_q.filt);

        // Quantum prescaler: 1, 2, 4 or 8 clocks per quantum
        tq_en = s_q.pre == 3'((4'h1 << s_q.csel) - 4'h1);
        s_d.pre = tq_en ? 3'h0 : s_q.pre + 3'h1;
        // Bit timer; sample point beyond bit length never samples
        smp = tq_en && s_q.tq == s_q.sp;
        if (tq_en) s_d.tq = s_q.tq == s_q.wbt ? 6'h00 : s_q.tq + 6'h01;
        fall = s_q.rxp && !rx_f;
        s_d.rxp = rx_f;

        // Edge handling: hard sync at idle, recovery inside a frame
        nb = s_q.wbt;
        lim_hit = 1'b0;
        if (fall && s_q.fs == FS_IDLE) begin
            s_d.tq = 6'h00;
            s_d.pre = 3'h0;
            s_d.wbt = s_q.bt;
        end else if (fall && s_q.recovery_enable) begin
            // Late edge stretches the bit, early edge shortens it
            if (s_q.tq > (s_q.wbt >> 1)) nb = s_q.wbt - 6'h01;
            else if (s_q.tq != 6'h00) nb = s_q.wbt + 6'h01;
            lim_hit = nb > s_q.lhi || nb < s_q.llo;
            s_d.wbt = lim_hit ? s_q.bt : nb;
            s_d.tq = 6'h00;
            s_d.pre = 3'h0;
        end

        // Frame decoder, runs on sample points
        stuffed = (s_q.fs == FS_HDR || s_q.fs == FS_CLS) && s_q.run == STUFF_LEN;
        // Recessive runs are allowed so the frame tail is not an error
        serr = smp && stuffed && rx_f == s_q.last && !rx_f;
        eof = smp && rx_f && s_q.rec == EOF_LEN - 3'h1;
        fd_det = 1'b0;
        good_cls = 1'b0;
        good_fd = 1'b0;
        if (smp) begin
            s_d.rec = !rx_f ? 3'h0 : (s_q.rec == EOF_LEN ? s_q.rec : s_q.rec + 3'h1);
            s_d.run = rx_f != s_q.last ? 3'h1 :
                (s_q.run == EOF_LEN ? s_q.run : s_q.run + 3'h1);
            s_d.last = rx_f;
            case (s_q.fs)
                FS_IDLE: if (!rx_f) begin
                    s_d.fs = FS_HDR;
                    s_d.idx = 7'h01;
                    s_d.id = '0;
                    s_d.fdt = 1'b0;
                end
                FS_HDR: if (serr) begin
                    s_d.fs = FS_SKIP;
                end else if (stuffed) begin
                    s_d.run = 3'h1; // Stuff bit dropped
                end else begin
                    s_d.idx = s_q.idx + 7'h01;
                    if (s_q.idx <= IDX_ID_END) s_d.id = {s_q.id[9:0], rx_f};
                    if (s_q.idx == IDX_EDL) begin
                        fd_det = rx_f;
                        s_d.fdt = rx_f && s_q.tol;
                        s_d.fs = rx_f ? FS_SKIP : FS_CLS;
                    end
                end
                FS_CLS: if (serr) s_d.fs = FS_SKIP;
                else if (eof) begin
                    good_cls = 1'b1;
                    s_d.fs = FS_IDLE;
                end else if (stuffed) s_d.run = 3'h1;
                // No checks at all while skipping
                FS_SKIP: if (eof) begin
                    good_fd = s_q.fdt;
                    s_d.fs = FS_IDLE;
                end
                default: s_d.fs = FS_IDLE;
            endcase
        end

        // Error counter
        inc = serr || (fd_det && !s_q.tol);
        dec = good_cls || good_fd;
        ovf_ev = 1'b0;
        if (s_q.tol && s_q.hold) s_d.frame_error_count = '0;
        else if (s_q.frame_error_count == FRAME_ERROR_COUNT_OVF) s_d.frame_error_count = FRAME_ERROR_COUNT_OVF;
        else if (inc) begin
            s_d.frame_error_count = s_q.frame_error_count + 6'h01;
            ovf_ev = s_q.frame_error_count == FRAME_ERROR_COUNT_OVF - 6'h01;
        end else if (dec && s_q.frame_error_count != '0) s_d.frame_error_count = s_q.frame_error_count - 6'h01;

        // Bus silence timer, counted on the raw receive level
        sil_exp = s_q.rxs && !s_q.sdone && s_q.sil == SIL_LAST;
        s_d.sil = !s_q.rxs ? 24'h0 : (sil_exp ? s_q.sil : s_q.sil + 24'h1);
        if (!s_q.rxs) s_d.sdone = 1'b0;
        else if (sil_exp) s_d.sdone = 1'b1;
        if (sil_exp) s_d.hold = 1'b0;

        // Wake causes; pattern wake only in plain wake mode
        wuf_ev = good_cls && s_q.mode[2] && s_q.mode[1:0] != 2'b00 &&
            ((s_q.id ^ s_q.wid) & ~s_q.wmsk) == '0;
        pat_ev = s_q.sdone && !s_q.rxs && s_q.mode == 3'h1;
        wk_ev = wuf_ev || ovf_ev || pat_ev;
        // Sets come after clears so a same-cycle event survives
        if (wk_ev) s_d.wake = 1'b1;
        if (pat_ev) s_d.pat = 1'b1;
        if (wuf_ev) s_d.wuf = 1'b1;
        if (ovf_ev) s_d.cfg = 1'b1;
        s_d.irq = wk_ev && !chip_sleep;
        s_d.rst = wk_ev && chip_sleep;

        // Oscillator pulse measurement, CAN off, pulse is low on the pin
        meas = s_q.osc_en && s_q.mode == 3'h0;
        if (meas && s_q.txs && s_q.tx[2] == s_q.tx[1] && !s_q.tx[2]) s_d.osc = '0;
        else if (meas && !s_q.txs && s_q.osc != 16'hffff) s_d.osc = s_q.osc + 16'h1;
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) s_q <= ST_RST;
        else s_q <= s_d;
    end

    // Outputs straight from the record
    assign hrdata = s_q.rdata;
    assign hreadyout = s_q.rdy;
    assign hresp = s_q.cfg && 1'b0;
    assign wake_irq = s_q.irq;
    assign restart_req = s_q.rst;
    assign osc_trim = s_q.trim;
    assign osc_option = s_q.opt;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_edl_fd; fd_det; endsequence
    sequence s_skip_end; s_q.fs == FS_SKIP && eof; endsequence

    a_hold_zero: assert property (s_q.tol && s_q.hold |=> s_q.frame_error_count == '0)
        else $error("count not held at zero");
    a_ovf_wake: assert property (ovf_ev |=> s_q.wake && s_q.cfg && s_q.frame_error_count == FRAME_ERROR_COUNT_OVF)
        else $error("overflow did not wake");
    a_sleep_restart: assert property (wk_ev && chip_sleep |=> restart_req && !wake_irq)
        else $error("no restart on sleep wake");
    a_awake_irq: assert property (wk_ev && !chip_sleep |=> wake_irq ##1 !wake_irq)
        else $error("no single interrupt pulse");
    a_trim_gate: assert property ($changed(s_q.trim) |-> $past(s_q.osc_en && s_q.trim_en == 2'b11))
        else $error("trim changed while locked");
    a_osc_run: assert property ($changed(s_q.osc) |-> $past(meas))
        else $error("measure count moved idle");
    a_fd_halt: assert property (s_edl_fd |=> s_q.fs == FS_SKIP && !wuf_ev)
        else $error("fast frame not skipped");
    a_fd_ready: assert property (s_skip_end |=> s_q.fs == FS_IDLE)
        else $error("decoder not ready after end");
    a_lim_reload: assert property (lim_hit |=> s_q.wbt == $past(s_q.bt))
        else $error("bit time not reloaded");
    a_sil_clear: assert property (sil_exp |=> !s_q.hold)
        else $error("hold not cleared on silence");
    a_tol_dec: assert property (good_fd && !inc && !s_q.hold && s_q.frame_error_count != '0 &&
        s_q.frame_error_count != FRAME_ERROR_COUNT_OVF |=> s_q.frame_error_count == $past(s_q.frame_error_count) - 6'h01)
        else $error("no decrement on fast frame");
endmodule

// ---- shared/swd_pkg.sv ----
// Register map, frame constants and state record of the wake decoder
package swd_pkg;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_BITQ = 8'h04;
    localparam logic [7:0] A_SAMP = 8'h08;
    localparam logic [7:0] A_RCTL = 8'h0c;
    localparam logic [7:0] A_RCLK = 8'h10;
    localparam logic [7:0] A_RHI = 8'h14;
    localparam logic [7:0] A_RLO = 8'h18;
    localparam logic [7:0] A_FILT = 8'h1c;
    localparam logic [7:0] A_WID = 8'h20;
    localparam logic [7:0] A_WMSK = 8'h24;
    localparam logic [7:0] A_STAT = 8'h28;
    localparam logic [7:0] A_OSCH = 8'h2c;
    localparam logic [7:0] A_OSCL = 8'h30;
    localparam logic [7:0] A_TRIM = 8'h34;
    localparam logic [7:0] A_OPT = 8'h38;
    // Bit positions inside a base frame, SOF is 0
    localparam logic [6:0] IDX_ID_END = 7'h0b;
    localparam logic [6:0] IDX_EDL = 7'h0e;
    // Counter overflow value, run lengths
    localparam logic [5:0] FRAME_ERROR_COUNT_OVF = 6'h20;
    localparam logic [2:0] EOF_LEN = 3'h7;
    localparam logic [2:0] STUFF_LEN = 3'h5;
    // Silence window is 0.6 s to 1.2 s; the short end is taken
    localparam real SILENCE_S = 0.6;
    localparam real CLK_HZ = 25.0e6;
    localparam int SILENCE_CYC = int'($ceil(SILENCE_S * CLK_HZ));
    // Frame decoder states
    typedef enum logic [1:0] {FS_IDLE, FS_HDR, FS_CLS, FS_SKIP} swd_fs_t;
    // Whole state of the block
    typedef struct packed {
        logic tol; logic hold; logic rxsel; logic [2:0] mode;
        logic osc_en; logic [1:0] trim_en;
        logic [5:0] bt; logic [5:0] sp; logic recovery_enable; logic [1:0] csel;
        logic [5:0] lhi; logic [5:0] llo; logic [7:0] filt;
        logic [10:0] wid; logic [10:0] wmsk; logic [7:0] trim; logic [7:0] opt;
        logic wake; logic pat; logic wuf; logic cfg; logic [5:0] frame_error_count;
        logic [15:0] osc;
        logic rdy; logic [31:0] rdata; logic ap; logic [7:0] aa; logic aw;
        logic [2:0] ra; logic [2:0] rb; logic [2:0] tx; logic rxs; logic txs;
        logic [2:0] pre; logic [5:0] tq; logic [5:0] wbt; logic rxp;
        swd_fs_t fs; logic [6:0] idx; logic [2:0] run; logic last;
        logic [10:0] id; logic [2:0] rec; logic fdt; logic [7:0] dom;
        logic [23:0] sil; logic sdone; logic irq; logic rst;
    } swd_st_t;
    // Values after reset
    localparam swd_st_t ST_RST = '{bt: 6'h3f, sp: 6'h33, lhi: 6'h3f, llo: 6'h20,
        wbt: 6'h3f, ra: 3'h7, rb: 3'h7, tx: 3'h7, rxs: 1'b1, txs: 1'b1,
        rxp: 1'b1, last: 1'b1, rdy: 1'b1, fs: FS_IDLE, default: '0};
endpackage

// ---- verification/swd_can_node.sv ----
// Bus node model that sends stuffed base-format frames on either receive path
`timescale 1ns/100ps
module swd_can_node (
    // Clock
    input wire logic hclk,
    // Receive paths, recessive high
    output logic rx_main,
    output logic rx_wake
);
    // Idle bus stays recessive on both paths
    initial begin
        rx_main = 1'b1;
        rx_wake = 1'b1;
    end
    // One frame; clks sets the node's own bit length, so it can run fast or slow
    task automatic send(input logic [10:0] id, input logic edl, input logic wk, input int clks);
        logic [34:0] body;
        logic q[$];
        logic prev;
        int run;
        // Start, identifier, two control bits, format bit, length 0, checksum
        body = {1'b0, id, 2'b00, edl, 5'h00, 15'h1234};
        prev = 1'b1;
        run = 0;
        for (int i = 34; i >= 0; i--) begin
            q.push_back(body[i]);
            run = (body[i] == prev) ? run + 1 : 1;
            prev = body[i];
            // Opposite bit after five equal ones
            if (run == 5) begin
                q.push_back(~prev);
                prev = ~prev;
                run = 1;
            end
        end
        // Delimiter, dominant acknowledge, then ack delimiter, end field and gap all recessive
        for (int i = 0; i < 12; i++)
            q.push_back(i != 1);
        foreach (q[i]) begin
            repeat (clks) begin
                @(posedge hclk);
                if (wk) begin
                    rx_wake <= q[i];
                end else begin
                    rx_main <= q[i];
                end
            end
        end
    endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the wake decoder: bus tasks, frames, pulse measurement
`timescale 1ns/100ps
module testbench;
    import swd_pkg::*;
    // Design inputs, all set at time zero
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = '0;
    logic can_transmit_input = 1'b1;
    logic chip_sleep = 1'b0;
    // Design outputs and bus lines
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic rx_main;
    logic rx_wake;
    logic wake_irq;
    logic restart_req;
    logic [7:0] osc_trim;
    logic [7:0] osc_option;
    // Scoreboard
    int miscompares = 0;
    int comparisons = 0;
    int n_irq = 0;
    int n_rst = 0;
    int e_irq = 0;
    int e_rst = 0;
    logic [31:0] rv;
    // Reset value table, last entry is a hole in the map
    logic [7:0] reg_a [16] = '{A_CTRL, A_BITQ, A_SAMP, A_RCTL, A_RCLK, A_RHI, A_RLO, A_FILT,
        A_WID, A_WMSK, A_STAT, A_OSCH, A_OSCL, A_TRIM, A_OPT, 8'h3c};
    logic [31:0] reg_v [16] = '{0, 'h3f, 'h33, 0, 0, 'h3f, 'h20, 0, 0, 0, 0, 0, 0, 0, 0, 0};

    // 25 MHz clock
    always #20 hclk = ~hclk;

    // Short silence window keeps the run brief
    swd_decoder #(.SILENCE(2000)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_main(rx_main),
        .rx_wake(rx_wake), .can_transmit_input(can_transmit_input),
        .chip_sleep(chip_sleep), .wake_irq(wake_irq), .restart_req(restart_req),
        .osc_trim(osc_trim), .osc_option(osc_option));

    // Far-side bus node
    swd_can_node node (.hclk(hclk), .rx_main(rx_main), .rx_wake(rx_wake));

    // Count the one-cycle wake pulses
    always @(posedge hclk) begin
        if (wake_irq === 1'b1)
            n_irq <= n_irq + 1;
        if (restart_req === 1'b1)
            n_rst <= n_rst + 1;
    end

    // Verdict and end of run
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Compare one value against its expectation
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One single word transfer; each phase waits for ready, bounded
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 20);
            if (hreadyout !== 1'b1) begin
                miscompares++;
                report_and_stop();
            end
            // Address taken: go idle, data phase follows
            if (p == 0) begin
                hsel <= 1'b0;
                htrans <= 2'b00;
                hwdata <= wd;
            end
        end
        rv = hrdata;
        // Slave never signals an error response
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(name, rv, exp);
    endtask

    // Send a frame, then compare the wake pulse counts
    task automatic frame(input logic [10:0] id, input logic edl, input logic wk, input int clks,
        input int di, input int dr);
        node.send(id, edl, wk, clks);
        repeat (4) @(posedge hclk);
        e_irq += di;
        e_rst += dr;
        check("wake_irq pulses", n_irq, e_irq);
        check("restart_req pulses", n_rst, e_rst);
    endtask

    // Low pulse of len clocks on the measurement pin, then settle
    task automatic pulse(input int len);
        @(posedge hclk);
        can_transmit_input <= 1'b0;
        repeat (len) @(posedge hclk);
        can_transmit_input <= 1'b1;
        repeat (10) @(posedge hclk);
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge hclk);
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (reg_a[i])
            rchk("reset value", reg_a[i], reg_v[i]);
        wr(8'h3c, 32'hffffffff);
        rchk("hole", 8'h3c, 32'h0);
        // Pulse with measurement off must not count
        pulse(300);
        rchk("count off", A_OSCL, 32'h0);
        // Trim refused without the measure bit
        wr(A_CTRL, 32'h600);
        wr(A_TRIM, 32'ha5);
        rchk("trim locked", A_TRIM, 32'h0);
        wr(A_CTRL, 32'h700);
        wr(A_TRIM, 32'ha5);
        wr(A_OPT, 32'h5a);
        rchk("trim", A_TRIM, 32'ha5);
        check("trim pins", {osc_option, osc_trim}, 32'h5aa5);
        wr(A_CTRL, 32'h100);
        wr(A_TRIM, 32'h33);
        rchk("trim closed", A_TRIM, 32'ha5);
        // Measurement with bus off: 300 clocks
        pulse(300);
        rchk("count high", A_OSCH, 32'h1);
        rchk("count low", A_OSCL, 32'h2c);
        repeat (50) @(posedge hclk);
        rchk("count held", A_OSCL, 32'h2c);
        // Selective wake, awake then sleeping
        wr(A_WID, 32'h5a3);
        wr(A_CTRL, 32'h50);
        frame(11'h5a3, 1'b0, 1'b0, 64, 1, 0);
        rchk("status", A_STAT, 32'h5);
        wr(A_STAT, 32'hf);
        chip_sleep <= 1'b1;
        frame(11'h5a3, 1'b0, 1'b0, 64, 0, 1);
        chip_sleep <= 1'b0;
        wr(A_STAT, 32'hf);
        frame(11'h123, 1'b0, 1'b0, 64, 0, 0);
        // Error counting with tolerance off
        frame(11'h5a3, 1'b1, 1'b0, 64, 0, 0);
        frame(11'h5a3, 1'b1, 1'b0, 64, 0, 0);
        rchk("count up", A_STAT, 32'h200);
        frame(11'h123, 1'b0, 1'b0, 64, 0, 0);
        rchk("count down", A_STAT, 32'h100);
        // Tolerance on: fast frame counts down, no wake, next frame decoded
        wr(A_CTRL, 32'h51);
        frame(11'h5a3, 1'b1, 1'b0, 64, 0, 0);
        rchk("tolerant down", A_STAT, 32'h0);
        frame(11'h5a3, 1'b0, 1'b0, 64, 1, 0);
        wr(A_STAT, 32'hf);
        // Counter hold, then cleared by silence
        wr(A_CTRL, 32'h50);
        frame(11'h123, 1'b1, 1'b0, 64, 0, 0);
        wr(A_CTRL, 32'h53);
        rchk("held zero", A_STAT, 32'h0);
        repeat (2100) @(posedge hclk);
        rchk("hold cleared", A_CTRL, 32'h51);
        // Plain wake mode after silence: first dominant edge wakes
        wr(A_CTRL, 32'h10);
        frame(11'h123, 1'b0, 1'b0, 64, 1, 0);
        rchk("pattern", A_STAT, 32'h3);
        // Receiver path select
        wr(A_CTRL, 32'h54);
        frame(11'h5a3, 1'b0, 1'b0, 64, 0, 0);
        frame(11'h5a3, 1'b0, 1'b1, 64, 1, 0);
        // Half the quanta at twice the quantum length
        wr(A_CTRL, 32'h50);
        wr(A_RCLK, 32'h1);
        wr(A_BITQ, 32'h1f);
        wr(A_SAMP, 32'h19);
        frame(11'h5a3, 1'b0, 1'b0, 64, 1, 0);
        // Short bits keep the overflow run brief; 32 fast frames overflow
        wr(A_RCLK, 32'h0);
        wr(A_BITQ, 32'h7);
        wr(A_SAMP, 32'h5);
        wr(A_STAT, 32'h1f);
        for (int i = 0; i < 32; i++)
            frame(11'h123, 1'b1, 1'b0, 8, i == 31, 0);
        rchk("overflow", A_STAT, 32'h2009);
        // Recovery set up with the bus off, then a fast node
        wr(A_CTRL, 32'h0);
        wr(A_RCLK, 32'h0);
        wr(A_BITQ, 32'h3f);
        wr(A_SAMP, 32'h33);
        wr(A_RHI, 32'h3f);
        wr(A_RLO, 32'h20);
        wr(A_RCTL, 32'h1);
        wr(A_CTRL, 32'h50);
        frame(11'h5a3, 1'b0, 1'b0, 61, 1, 0);
        // Tight lower limit: every adjustment reloads, decoding still works
        wr(A_CTRL, 32'h0);
        wr(A_RCTL, 32'h0);
        wr(A_RLO, 32'h3f);
        wr(A_RCTL, 32'h1);
        wr(A_CTRL, 32'h50);
        frame(11'h5a3, 1'b0, 1'b0, 64, 1, 0);
        report_and_stop();
    end
endmodule
